/* File: core/fe_rx_map.svh */
// Constants for the 100BASE-TX receive path: code-groups, counts, timing.
// Assumes inclusion by the receive path top module and the bench files.
`ifndef FE_RX_MAP_SVH
`define FE_RX_MAP_SVH
`define CG_IDLE 5'h1f
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0d
`define CG_R 5'h07
`define CG_H 5'h04
`define SSD_LEAD 3'h6
`define NIB_PRE 4'h5
`define NIB_BAD_SSD 4'he
`define NIB_ZERO 4'h0
`define IDLE_LOCK_GROUPS 12
`define IDLE_KEEP_BITS 58
`define HOLD_TIME_US 722
`define LINK_TIME_US 395
`define LINK_CLK_MHZ 125
`define SYS_CLK_MHZ 10
`define CFG_FORCE_SD_BIT 1
`define CFG_LOCK_REQ_BIT 8
`define CFG_WIDTH 16
`define SYM_WIDTH 5
`define LFSR_WIDTH 11
`define LFSR_TAP_A 10
`define LFSR_TAP_B 8
`define MLT_ZERO 2'h0
`define MLT_POS 2'h1
`define MLT_NEG 2'h3
`define EQ_WIDTH 6
`endif

/* File: core/fe_rx_pkg.sv */
// Types for the 100BASE-TX receive path.
// Assumes nothing beyond a SystemVerilog compiler.
package fe_rx_pkg;
	typedef enum logic [1:0] {
		LNK_DOWN = 2'h0,
		LNK_WAIT = 2'h1,
		LNK_UP = 2'h3
	} link_state_t;
	typedef enum logic [1:0] {
		DEC_IDLE = 2'h0,
		DEC_K = 2'h1,
		DEC_DATA = 2'h3,
		DEC_BAD = 2'h2
	} dec_state_t;
endpackage

/* File: core/fe_rx_path.sv */
// Receive path of a 100BASE-TX physical layer, line symbol to MAC nibble.
// Assumes equalized MLT-3 symbols and a recovered-clock tick on
// LINE_CLK_IN; signal detect, link monitor and config on CLK_IN.
`timescale 1ns/10ps
`include "fe_rx_map.svh"
module fe_rx_path
	import fe_rx_pkg::*;
#(
	parameter int HOLD_CYCLES = `HOLD_TIME_US * `LINK_CLK_MHZ,
	parameter int LINK_CYCLES = `LINK_TIME_US * `SYS_CLK_MHZ
) (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic CE_IN,
	input wire logic LINE_CLK_IN,
	input wire logic [1:0] MLT_SYM_IN,
	input wire logic SYM_TICK_IN,
	input wire logic SIG_DET_IN,
	input wire logic LINK_PULSE_IN,
	input wire logic [`EQ_WIDTH-1:0] EQ_LEVEL_IN,
	input wire logic [`CFG_WIDTH-1:0] PCS_CONFIG_REG_IN,
	input wire logic DESCR_BYPASS_IN,
	input wire logic RX_BYPASS_IN,
	output logic [3:0] RXD_OUT,
	output logic RXDV_OUT,
	output logic RXER_OUT,
	output logic [4:0] BYPASS_SYM_OUT,
	output logic DESCR_LOCK_OUT,
	output logic LINK_UP_OUT,
	output logic PCS_EN_OUT,
	output logic [15:0] FALSE_CARRIER_OUT,
	output logic [`EQ_WIDTH-1:0] EQ_LEVEL_OUT
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [4:0] dec_4b(input logic [4:0] cg);
		logic [4:0] r;
		r = 5'h10;
		case (cg)
			5'h1e: r = 5'h00;
			5'h09: r = 5'h01;
			5'h14: r = 5'h02;
			5'h15: r = 5'h03;
			5'h0a: r = 5'h04;
			5'h0b: r = 5'h05;
			5'h0e: r = 5'h06;
			5'h0f: r = 5'h07;
			5'h12: r = 5'h08;
			5'h13: r = 5'h09;
			5'h16: r = 5'h0a;
			5'h17: r = 5'h0b;
			5'h1a: r = 5'h0c;
			5'h1b: r = 5'h0d;
			5'h1c: r = 5'h0e;
			5'h1d: r = 5'h0f;
			default: r = 5'h10;
		endcase
		return r;
	endfunction
	// J/K gives K; a lone J would hide a bad start, so it becomes H
	function automatic logic [4:0] ssd_sym(input logic [9:0] w);
		logic [4:0] r;
		r = w[9:5];
		if (w == {`CG_J, `CG_K})
			r = `CG_K;
		else if (w[9:5] == `CG_J)
			r = `CG_H;
		return r;
	endfunction

	// ----------------------------------------
	// System to link crossing
	// ----------------------------------------
	// Link enable is a level; two flops, only the second is read
	logic pcs_en_q;
	logic en_meta_q, en_sync_q;
	always_ff @(posedge LINE_CLK_IN) begin
		en_meta_q <= pcs_en_q;
		en_sync_q <= en_meta_q;
	end

	// ----------------------------------------
	// Line decode (link domain)
	// ----------------------------------------
	// Clock tick comes from the phase loop; every stage steps on it
	logic tick;
	assign tick = SYM_TICK_IN;
	logic [1:0] prev_sym_q;
	logic nrzi_q, nrzi_prev_q, nrz_q, bit_v_q;
	always_ff @(posedge LINE_CLK_IN) begin
		if (!en_sync_q) begin
			prev_sym_q <= `MLT_ZERO;
			nrzi_q <= 1'b0;
			nrzi_prev_q <= 1'b0;
			nrz_q <= 1'b0;
			bit_v_q <= 1'b0;
		end else begin
			bit_v_q <= tick;
			if (tick) begin
				// Any level change on MLT-3 is an NRZI one
				prev_sym_q <= MLT_SYM_IN;
				nrzi_q <= (MLT_SYM_IN != prev_sym_q);
				nrzi_prev_q <= nrzi_q;
				// Level change already marks a one
				nrz_q <= nrzi_q;
			end
		end
	end

	// ----------------------------------------
	// Descrambler
	// ----------------------------------------
	logic [`LFSR_WIDTH-1:0] lfsr_q;
	logic lock_q;
	logic [3:0] idle_cnt_q;
	logic [2:0] ones_q;
	logic [5:0] keep_q;
	logic [16:0] hold_q;
	logic key, ud;
	assign key = lfsr_q[`LFSR_TAP_A] ^ lfsr_q[`LFSR_TAP_B];
	assign ud = nrz_q ^ key;
	always_ff @(posedge LINE_CLK_IN) begin
		if (!en_sync_q) begin
			lfsr_q <= '0;
			lock_q <= 1'b0;
			idle_cnt_q <= 4'h0;
			ones_q <= 3'h0;
			keep_q <= 6'h0;
			hold_q <= 17'h0;
		end else if (bit_v_q) begin
			if (!lock_q) begin
				// Idle descrambles to ones, so the inverted line bit seeds the key
				lfsr_q <= {lfsr_q[`LFSR_WIDTH-2:0], ~nrz_q};
				if (ud) begin
					ones_q <= (ones_q == 3'h4) ? 3'h0 : ones_q + 3'h1;
					if (ones_q == 3'h4)
						idle_cnt_q <= idle_cnt_q + 4'h1;
				end else begin
					ones_q <= 3'h0;
					idle_cnt_q <= 4'h0;
				end
				if (idle_cnt_q == 4'(`IDLE_LOCK_GROUPS)) begin
					lock_q <= 1'b1;
					hold_q <= 17'(HOLD_CYCLES);
					keep_q <= 6'h0;
				end
			end else begin
				lfsr_q <= {lfsr_q[`LFSR_WIDTH-2:0], key};
				keep_q <= ud ? keep_q + 6'h1 : 6'h0;
				if (keep_q == 6'(`IDLE_KEEP_BITS)) begin
					hold_q <= 17'(HOLD_CYCLES);
					keep_q <= 6'h0;
				end else if (hold_q == 17'h0) begin
					// Lock, idle counts and key cleared, search starts over
					lock_q <= 1'b0;
					idle_cnt_q <= 4'h0;
					ones_q <= 3'h0;
					lfsr_q <= '0;
				end else
					hold_q <= hold_q - 17'h1;
			end
		end
	end

	// ----------------------------------------
	// Serial to parallel and alignment
	// ----------------------------------------
	logic sel_bit;
	assign sel_bit = DESCR_BYPASS_IN ? nrz_q : ud;
	logic [9:0] win;
	assign win = {sh_q[8:0], sel_bit};
	logic [9:0] sh_q;
	logic [2:0] bcnt_q;
	logic aligned_q, sym_v_q;
	logic [4:0] sym_q;
	always_ff @(posedge LINE_CLK_IN) begin
		if (!en_sync_q) begin
			sh_q <= 10'h3ff;
			bcnt_q <= 3'h0;
			aligned_q <= 1'b0;
			sym_v_q <= 1'b0;
			sym_q <= `CG_IDLE;
		end else begin
			sym_v_q <= 1'b0;
			if (bit_v_q && (lock_q || DESCR_BYPASS_IN)) begin
				sh_q <= {sh_q[8:0], sel_bit};
				if (!aligned_q && win[9:7] == `SSD_LEAD) begin
					// First zero after idles fixes the boundary
					aligned_q <= 1'b1;
					bcnt_q <= 3'h0;
					sym_q <= ssd_sym(win);
					sym_v_q <= 1'b1;
				end else if (aligned_q || RX_BYPASS_IN) begin
					if (bcnt_q == 3'h4) begin
						bcnt_q <= 3'h0;
						sym_q <= {sh_q[3:0], sel_bit};
						sym_v_q <= 1'b1;
						if ({sh_q[8:0], sel_bit} ==
						    {`CG_IDLE, `CG_IDLE})
							aligned_q <= 1'b0;
					end else
						bcnt_q <= bcnt_q + 3'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Code-group decoder and bad start
	// ----------------------------------------
	dec_state_t dst_q;
	logic prev_idle_q;
	logic [1:0] idles_q;
	logic [3:0] rxd_l_q;
	logic dv_l_q, er_l_q, fc_tgl_q;
	logic [4:0] byp_q;
	logic [4:0] dv;
	assign dv = dec_4b(sym_q);
	always_ff @(posedge LINE_CLK_IN) begin
		if (!en_sync_q) begin
			dst_q <= DEC_IDLE;
			prev_idle_q <= 1'b1;
			idles_q <= 2'h0;
			rxd_l_q <= `NIB_ZERO;
			dv_l_q <= 1'b0;
			er_l_q <= 1'b0;
			fc_tgl_q <= 1'b0;
			byp_q <= `CG_IDLE;
		end else if (sym_v_q) begin
			byp_q <= sym_q;
			prev_idle_q <= (sym_q == `CG_IDLE);
			idles_q <= (sym_q == `CG_IDLE) ?
				((idles_q == 2'h2) ? idles_q : idles_q + 2'h1) : 2'h0;
			case (dst_q)
				DEC_IDLE: begin
					dv_l_q <= 1'b0;
					er_l_q <= 1'b0;
					if (sym_q == `CG_K && prev_idle_q) begin
						dst_q <= DEC_DATA;
						rxd_l_q <= `NIB_PRE;
						dv_l_q <= 1'b1;
					end else if (sym_q != `CG_IDLE && sym_q != `CG_J
					             && prev_idle_q) begin
						dst_q <= DEC_BAD;
						fc_tgl_q <= ~fc_tgl_q;
						rxd_l_q <= `NIB_BAD_SSD;
						er_l_q <= 1'b1;
					end
				end
				DEC_DATA: begin
					// T, R and a second idle in a row close the frame
					if (sym_q == `CG_T || sym_q == `CG_R ||
					    (sym_q == `CG_IDLE && idles_q != 2'h0)) begin
						dst_q <= DEC_IDLE;
						dv_l_q <= 1'b0;
						er_l_q <= 1'b0;
					end else if (sym_q == `CG_IDLE) begin
						dv_l_q <= 1'b0;
					end else begin
						rxd_l_q <= dv[3:0];
						er_l_q <= dv[4] || sym_q == `CG_H;
					end
				end
				DEC_BAD: begin
					rxd_l_q <= `NIB_BAD_SSD;
					er_l_q <= 1'b1;
					if (sym_q == `CG_IDLE && idles_q != 2'h0) begin
						dst_q <= DEC_IDLE;
						er_l_q <= 1'b0;
					end
				end
				default: dst_q <= DEC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Link to system crossing
	// ----------------------------------------
	// Nibble fields are steady across a symbol (8 ns x 5), so a
	// two-flop copy on the 100 ns clock is sampled as levels; the
	// counter event crosses as a toggle to keep each one.
	logic [7:0] rx_m_q, rx_s_q;
	logic lk_m_q, lk_s_q, fc_m_q, fc_s_q, fc_d_q;
	logic [4:0] byp_m_q, byp_s_q;
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			rx_m_q <= 8'h0;
			rx_s_q <= 8'h0;
			lk_m_q <= 1'b0;
			lk_s_q <= 1'b0;
			fc_m_q <= 1'b0;
			fc_s_q <= 1'b0;
			fc_d_q <= 1'b0;
			byp_m_q <= `CG_IDLE;
			byp_s_q <= `CG_IDLE;
		end else if (CE_IN) begin
			byp_m_q <= byp_q;
			byp_s_q <= byp_m_q;
			rx_m_q <= {dv_l_q, er_l_q, rxd_l_q, 2'h0};
			rx_s_q <= rx_m_q;
			lk_m_q <= lock_q;
			lk_s_q <= lk_m_q;
			fc_m_q <= fc_tgl_q;
			fc_s_q <= fc_m_q;
			fc_d_q <= fc_s_q;
		end
	end

	// ----------------------------------------
	// Link monitor (system domain)
	// ----------------------------------------
	logic sd_m_q, sd_s_q, lp_m_q, lp_s_q;
	logic sd_eff;
	link_state_t lst_q;
	logic [15:0] lcnt_q;
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			sd_m_q <= 1'b0;
			sd_s_q <= 1'b0;
			lp_m_q <= 1'b0;
			lp_s_q <= 1'b0;
		end else if (CE_IN) begin
			sd_m_q <= SIG_DET_IN;
			sd_s_q <= sd_m_q;
			lp_m_q <= LINK_PULSE_IN;
			lp_s_q <= lp_m_q;
		end
	end
	// Link pulses mask detect; forcing bit overrides both
	assign sd_eff = PCS_CONFIG_REG_IN[`CFG_FORCE_SD_BIT] ||
		(sd_s_q && !lp_s_q);
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			lst_q <= LNK_DOWN;
			lcnt_q <= 16'h0;
			pcs_en_q <= 1'b0;
		end else if (CE_IN) begin
			case (lst_q)
				LNK_DOWN: begin
					pcs_en_q <= 1'b0;
					lcnt_q <= 16'h0;
					if (sd_eff)
						lst_q <= LNK_WAIT;
				end
				LNK_WAIT: begin
					if (!sd_eff)
						lst_q <= LNK_DOWN;
					else if (lcnt_q >= 16'(LINK_CYCLES - 1)) begin
						if (!PCS_CONFIG_REG_IN[`CFG_LOCK_REQ_BIT] ||
						    lk_s_q) begin
							lst_q <= LNK_UP;
							pcs_en_q <= 1'b1;
						end
					end else
						lcnt_q <= lcnt_q + 16'h1;
				end
				LNK_UP: begin
					if (!sd_eff) begin
						lst_q <= LNK_DOWN;
						pcs_en_q <= 1'b0;
					end
				end
				default: lst_q <= LNK_DOWN;
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			RXD_OUT <= `NIB_ZERO;
			RXDV_OUT <= 1'b0;
			RXER_OUT <= 1'b0;
			BYPASS_SYM_OUT <= `CG_IDLE;
			DESCR_LOCK_OUT <= 1'b0;
			FALSE_CARRIER_OUT <= 16'h0;
			EQ_LEVEL_OUT <= '0;
		end else if (CE_IN) begin
			RXD_OUT <= rx_s_q[5:2];
			RXDV_OUT <= rx_s_q[7] && pcs_en_q;
			RXER_OUT <= rx_s_q[6] && pcs_en_q;
			BYPASS_SYM_OUT <= byp_s_q;
			DESCR_LOCK_OUT <= lk_s_q;
			if (fc_s_q != fc_d_q)
				FALSE_CARRIER_OUT <= FALSE_CARRIER_OUT + 16'h1;
			EQ_LEVEL_OUT <= EQ_LEVEL_IN;
		end
	end
	assign LINK_UP_OUT = (lst_q == LNK_UP);
	assign PCS_EN_OUT = pcs_en_q;

endmodule

/* File: tb/fe_rx_props.sv */
// Port checker for the receive path top module.
// Assumes bind onto fe_rx_path, LINK_CYCLES handed on.
`timescale 1ns/10ps
`include "fe_rx_map.svh"
module fe_rx_props
	import fe_rx_pkg::*;
#(
	parameter int LINK_CYCLES = 3950
) (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic SIG_DET_IN,
	input wire logic LINK_PULSE_IN,
	input wire logic [`CFG_WIDTH-1:0] PCS_CONFIG_REG_IN,
	input wire logic [`EQ_WIDTH-1:0] EQ_LEVEL_IN,
	input wire logic [3:0] RXD_OUT,
	input wire logic RXDV_OUT,
	input wire logic RXER_OUT,
	input wire logic DESCR_LOCK_OUT,
	input wire logic LINK_UP_OUT,
	input wire logic PCS_EN_OUT,
	input wire logic [15:0] FALSE_CARRIER_OUT,
	input wire logic [`EQ_WIDTH-1:0] EQ_LEVEL_OUT
);
	// ---
	// Detect run length
	// ---
	logic det;
	int run_q;
	assign det = (SIG_DET_IN | PCS_CONFIG_REG_IN[`CFG_FORCE_SD_BIT])
		& ~LINK_PULSE_IN;
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN || !det) begin
			run_q <= 0;
		end else begin
			run_q <= run_q + 1;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	AST_LINK_WAIT: assert property ($rose(LINK_UP_OUT) |-> run_q >= LINK_CYCLES)
		else $error("link up too early");
	AST_LINK_HOLD: assert property (!det [*6] |-> !LINK_UP_OUT)
		else $error("link kept without detect");
	AST_LOCK_ENTRY: assert property ($rose(LINK_UP_OUT) && PCS_CONFIG_REG_IN[`CFG_LOCK_REQ_BIT] |-> DESCR_LOCK_OUT || $past(DESCR_LOCK_OUT))
		else $error("link up without lock");
	AST_PCS_GATE: assert property (PCS_EN_OUT |-> LINK_UP_OUT || $past(LINK_UP_OUT))
		else $error("pcs on without link");
	AST_DOWN_QUIET: assert property (!LINK_UP_OUT [*6] |-> !RXDV_OUT && !DESCR_LOCK_OUT && !PCS_EN_OUT)
		else $error("activity while link down");
	AST_BAD_NIB: assert property (RXER_OUT && !RXDV_OUT |-> RXD_OUT == `NIB_BAD_SSD)
		else $error("bad start nibble wrong");
	AST_FC_STEP: assert property ($changed(FALSE_CARRIER_OUT) |-> FALSE_CARRIER_OUT == $past(FALSE_CARRIER_OUT) + 16'h1)
		else $error("counter step not one");
	AST_PREAMBLE: assert property ($rose(RXDV_OUT) |-> RXD_OUT == `NIB_PRE)
		else $error("frame not opened by preamble");
	AST_EQ_COPY: assert property ($stable(EQ_LEVEL_IN) [*4] |-> EQ_LEVEL_OUT == EQ_LEVEL_IN)
		else $error("equalizer copy stale");
endmodule
bind fe_rx_path fe_rx_props #(.LINK_CYCLES(LINK_CYCLES)) props (
	.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .SIG_DET_IN(SIG_DET_IN),
	.LINK_PULSE_IN(LINK_PULSE_IN), .PCS_CONFIG_REG_IN(PCS_CONFIG_REG_IN),
	.EQ_LEVEL_IN(EQ_LEVEL_IN), .RXD_OUT(RXD_OUT), .RXDV_OUT(RXDV_OUT),
	.RXER_OUT(RXER_OUT), .DESCR_LOCK_OUT(DESCR_LOCK_OUT),
	.LINK_UP_OUT(LINK_UP_OUT), .PCS_EN_OUT(PCS_EN_OUT),
	.FALSE_CARRIER_OUT(FALSE_CARRIER_OUT), .EQ_LEVEL_OUT(EQ_LEVEL_OUT)
);

/* File: tb/fe_rx_line_model.sv */
// Far-end partner: scrambles, codes MLT-3, paces symbol ticks.
// Assumes the bench runs the recovered clock and calls send_group.
`timescale 1ns/10ps
`include "fe_rx_map.svh"
module fe_rx_line_model (
	input wire logic line_clk_in,
	output logic [1:0] sym_out,
	output logic tick_out
);
	// ---
	// Line coder
	// ---
	logic [10:0] key_q = 11'h5a3;
	int step_q = 0;
	initial begin
		sym_out = `MLT_ZERO;
		tick_out = 1'b0;
	end
	// Leftmost bit first; symbol held four link cycles
	task automatic send_group(input logic [4:0] grp, input logic scr);
		logic key;
		for (int i = 4; i >= 0; i--) begin
			key = key_q[`LFSR_TAP_A] ^ key_q[`LFSR_TAP_B];
			key_q = {key_q[9:0], key};
			if (grp[i] ^ (key & scr)) begin
				step_q = (step_q + 1) % 4;
			end
			@(posedge line_clk_in);
			#1;
			sym_out = step_q == 1 ? `MLT_POS : step_q == 3 ? `MLT_NEG : `MLT_ZERO;
			tick_out = 1'b1;
			@(posedge line_clk_in);
			#1;
			tick_out = 1'b0;
			repeat (2) @(posedge line_clk_in);
		end
	endtask
endmodule

/* File: tb/tb.sv */
// Bench: link, lock, frames, bad starts, hold timer, bypass.
// Assumes the line model stands for the far end.
`timescale 1ns/10ps
`include "fe_rx_map.svh"
module tb;
	import fe_rx_pkg::*;
	localparam int LINKC = 20;
	logic clk = 0, line_clk = 0, srst = 1, sig_det = 0, pulse = 0, dbyp = 0;
	logic [`CFG_WIDTH-1:0] cfg = '0;
	logic [1:0] sym;
	logic tick, dv, er, lock, up;
	logic [3:0] rxd;
	logic [15:0] fc;
	logic [5:0] eq = 6'h2a, eqo;
	logic [4:0] bsym;
	logic pen;
	logic seen_pre, seen_a, seen_err;
	int failures = 0, checks = 0, cyc = 0;
	always #50 clk = ~clk;
	initial begin
		#3;
		forever #7.5 line_clk = ~line_clk;
	end
	fe_rx_path #(.HOLD_CYCLES(2000), .LINK_CYCLES(LINKC)) dut (
		.CLK_IN(clk), .SRST_IN(srst), .CE_IN(1'b1), .LINE_CLK_IN(line_clk),
		.MLT_SYM_IN(sym), .SYM_TICK_IN(tick), .SIG_DET_IN(sig_det),
		.LINK_PULSE_IN(pulse), .EQ_LEVEL_IN(eq), .PCS_CONFIG_REG_IN(cfg),
		.DESCR_BYPASS_IN(dbyp), .RX_BYPASS_IN(1'b0), .RXD_OUT(rxd),
		.RXDV_OUT(dv), .RXER_OUT(er), .BYPASS_SYM_OUT(bsym),
		.DESCR_LOCK_OUT(lock), .LINK_UP_OUT(up), .PCS_EN_OUT(pen),
		.FALSE_CARRIER_OUT(fc), .EQ_LEVEL_OUT(eqo)
	);
	fe_rx_line_model line (.line_clk_in(line_clk), .sym_out(sym),
		.tick_out(tick));
	// ---
	// Shared tasks
	// ---
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic send(input int n, input logic [4:0] g, input logic s);
		repeat (n) line.send_group(g, s);
	endtask
	// Nibbles are sampled levels, so flags collect what passes
	always @(posedge clk) begin
		cyc++;
		seen_pre |= dv === 1'b1 && rxd === `NIB_PRE;
		seen_a |= dv === 1'b1 && rxd === 4'ha;
		seen_err |= er === 1'b1 && dv === 1'b0 && rxd === `NIB_BAD_SSD;
		if (cyc == 6000) begin
			failures++;
			stop_test();
		end
	end
	// ---
	// Scenarios
	// ---
	task automatic t_link();
		int i;
		pulse = 1'b1;
		sig_det = 1'b1;
		step(3 * LINKC);
		check(16'(up), 16'h0);
		pulse = 1'b0;
		sig_det = 1'b0;
		cfg[`CFG_FORCE_SD_BIT] = 1'b1;
		for (i = 0; i < LINKC + 9 && up !== 1'b1; i++) step(1);
		check(16'(i >= LINKC && up === 1'b1), 16'h1);
		cfg = '0;
		step(8);
		check(16'(up), 16'h0);
		cfg[`CFG_LOCK_REQ_BIT] = 1'b1;
		sig_det = 1'b1;
		step(3 * LINKC);
		check(16'(up), 16'h0);
		cfg = '0;
		step(LINKC + 8);
		check(16'(up), 16'h1);
		check(16'(pen), 16'h1);
		eq = 6'h15;
		step(3);
		check(16'(eqo), 16'h15);
	endtask
	task automatic t_lock();
		send(8, `CG_IDLE, 1'b1);
		step(4);
		check(16'(lock), 16'h0);
		send(14, `CG_IDLE, 1'b1);
		step(4);
		check(16'(lock), 16'h1);
	endtask
	task automatic t_frame(input logic s);
		logic [4:0] f[9] = '{`CG_IDLE, `CG_IDLE, `CG_J, `CG_K, 5'h0b, 5'h16,
			5'h16, `CG_T, `CG_R};
		seen_pre = 1'b0;
		seen_a = 1'b0;
		foreach (f[i]) line.send_group(f[i], s);
		send(3, `CG_IDLE, s);
		check(16'(seen_pre), 16'h1);
		check(16'(seen_a), 16'h1);
		check(16'(dv), 16'h0);
		check(16'(bsym), 16'(`CG_IDLE));
	endtask
	task automatic t_bad();
		logic [15:0] fc0;
		fc0 = fc;
		seen_err = 1'b0;
		send(3, 5'h16, 1'b1);
		send(4, `CG_IDLE, 1'b1);
		step(6);
		check(16'(seen_err), 16'h1);
		check(fc, fc0 + 16'h1);
		check(16'(er), 16'h0);
	endtask
	task automatic t_hold();
		send(150, `CG_IDLE, 1'b1);
		check(16'(lock), 16'h1);
		send(450, 5'h16, 1'b1);
		step(4);
		check(16'(lock), 16'h0);
	endtask
	initial begin
		step(6);
		srst = 1'b0;
		t_link();
		t_lock();
		t_frame(1'b1);
		t_bad();
		t_hold();
		dbyp = 1'b1;
		send(4, `CG_IDLE, 1'b0);
		t_frame(1'b0);
		stop_test();
	end
endmodule
